// ===== rtl/spi_front.sv
`timescale 1ns/1ps
`default_nettype none
module spi_front (
	input wire logic core_clk, // 125 MHz core clock
	input wire logic resetn, // async reset, active low
	input wire logic cs_n, // chip select pin, active low
	input wire logic sck, // serial clock pin
	input wire logic [3:0] lane_in, // lane pin levels (lane2 write protect, lane3 reset)
	output logic [3:0] lane_out, // lane drive values
	output logic [3:0] lane_oe, // lane drive enables, high drives
	output logic rd_req, // pulse: fetch byte at mem_addr
	output logic [spi_front_pkg::MEM_ADDR_W-1:0] mem_addr, // byte location
	input wire logic [7:0] rd_data, // fetched byte, one cycle after rd_req
	output logic wr_valid, // written byte waiting
	output spi_front_pkg::wr_word_t wr_word, // address and byte written
	input wire logic wr_ready, // user takes written byte
	output logic write_overrun, // sticky: written byte lost
	input wire logic status_write_disable_bit, // write-disable bit of first_status_register
	input wire logic [7:0] second_config_register_vol, // volatile copy
	input wire logic [7:0] second_config_register_nv, // nonvolatile copy
	output logic reg_write_allowed, // status/config writes permitted
	output logic standby // chip deselected
);
	import spi_front_pkg::*;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);
	typedef enum {ST_IDLE, ST_OPC, ST_ADDR, ST_DIN, ST_DOUT, ST_SKIP} state_t;
	// ****************************************
	// helpers
	// ****************************************
	// opcode picks lane widths; in a multi-lane protocol only plain read/write exist
	function automatic op_info_t decode_op(input logic [7:0] op, input logic [2:0] pw);
		op_info_t r;
		r = INFO_IDLE;
		if (pw != W1) begin
			r.valid = (op == OPC_READ) || (op == OPC_WRITE);
			r.write = (op == OPC_WRITE);
			r.addr_w = pw;
			r.data_w = pw;
		end else begin
			case (op)
				OPC_READ: r.valid = 1'b1;
				OPC_WRITE: r = '{valid: 1'b1, write: 1'b1, addr_w: W1, data_w: W1};
				OPC_READ_DUAL_DATA: r = '{valid: 1'b1, write: 1'b0, addr_w: W1, data_w: W2};
				OPC_READ_DUAL_IO: r = '{valid: 1'b1, write: 1'b0, addr_w: W2, data_w: W2};
				OPC_READ_QUAD_DATA: r = '{valid: 1'b1, write: 1'b0, addr_w: W1, data_w: W4};
				OPC_READ_QUAD_IO: r = '{valid: 1'b1, write: 1'b0, addr_w: W4, data_w: W4};
				OPC_WRITE_QUAD_DATA: r = '{valid: 1'b1, write: 1'b1, addr_w: W1, data_w: W4};
				default: r = INFO_IDLE;
			endcase
		end
		return r;
	endfunction
	function automatic logic [3:0] oe_mask(input logic [2:0] w);
		return (w == W4) ? OE_W4 : ((w == W2) ? OE_W2 : OE_W1);
	endfunction
	// top bits of the byte onto the lanes, top lane most significant
	function automatic logic [3:0] drive_bits(input logic [7:0] b, input logic [2:0] w);
		logic [3:0] r;
		r = '0;
		case (w)
			W4: r = b[7:4];
			W2: r[1:0] = b[7:6];
			default: r[1] = b[7];
		endcase
		return r;
	endfunction
	// ****************************************
	// pin sampling and edges
	// ****************************************
	logic cs_s, sck_s, cs_d, sck_d;
	logic [3:0] lane_s;
	pin_sync #(.WIDTH(6), .INIT(6'h2D)) u_sync (
		.core_clk(core_clk),
		.resetn(resetn),
		.pin({cs_n, sck, lane_in}),
		.synced({cs_s, sck_s, lane_s})
	);
	logic rise, fall, cs_high, cs_fall, quad_in_use, rst_pin, wp_low;
	logic [2:0] pw, cur_w;
	op_info_t info, next_info;
	state_t state, next_state;
	// edges found by sampling, so any rate below core/8 and any pause works
	assign rise = sck_s && !sck_d && !cs_s;
	assign fall = !sck_s && sck_d && !cs_s;
	assign cs_high = cs_s;
	assign cs_fall = !cs_s && cs_d;
	// quad protocol wins when both copies ask for different widths
	assign pw = (second_config_register_vol[CFG2_FOUR_LANE_BIT] || second_config_register_nv[CFG2_FOUR_LANE_BIT])
		? W4
		: ((second_config_register_vol[CFG2_TWO_LANE_BIT] || second_config_register_nv[CFG2_TWO_LANE_BIT])
		? W2 : W1);
	// in four-lane use lanes 2 and 3 carry data, not protect and reset
	assign quad_in_use = (pw == W4) || (info.data_w == W4);
	assign rst_pin = !lane_s[LANE_RST] && !quad_in_use;
	assign wp_low = !lane_s[LANE_WP] && !quad_in_use;
	// lane width of the phase in progress
	always_comb begin
		case (state)
			ST_ADDR: cur_w = info.addr_w;
			ST_DIN, ST_DOUT: cur_w = info.data_w;
			default: cur_w = pw;
		endcase
	end
	// ****************************************
	// frame engine
	// ****************************************
	logic [7:0] sh, next_sh, byte_in, tx, next_tx, tx_next, next_tx_next;
	logic [3:0] cnt, next_cnt, bits_in, tx_left, next_tx_left;
	logic [1:0] abytes, next_abytes;
	logic [23:0] addr, next_addr, addr_full;
	logic [MEM_ADDR_W-1:0] next_mem_addr;
	logic rd_pend, next_rd_pend, next_rd_req, push, next_push;
	logic [3:0] next_lane_out, next_lane_oe;
	wr_word_t push_word, next_push_word;
	logic byte_done, fifo_ready, next_overrun, next_regwr;
	always_comb begin
		next_state = state;
		next_info = info;
		next_sh = sh;
		next_cnt = cnt;
		next_abytes = abytes;
		next_addr = addr;
		next_mem_addr = mem_addr;
		next_tx = tx;
		next_tx_left = tx_left;
		next_tx_next = rd_pend ? rd_data : tx_next;
		next_rd_pend = rd_req; // fetched byte stands the cycle after the pulse
		next_rd_req = 1'b0;
		next_lane_out = lane_out;
		next_lane_oe = lane_oe;
		next_push = 1'b0;
		next_push_word = push_word;
		// shift in the group, top lane most significant
		case (cur_w)
			W4: byte_in = {sh[3:0], lane_s};
			W2: byte_in = {sh[5:0], lane_s[1:0]};
			default: byte_in = {sh[6:0], lane_s[LANE_SI]};
		endcase
		bits_in = cnt + {1'b0, cur_w};
		byte_done = (bits_in == BYTE_BITS);
		addr_full = {addr[15:0], byte_in};
		case (state)
			ST_IDLE: begin
				if (cs_fall) begin
					next_state = ST_OPC;
					next_cnt = '0;
				end
			end
			ST_OPC: begin
				if (rise) begin
					next_sh = byte_in;
					next_cnt = byte_done ? 4'h0 : bits_in;
					if (byte_done) begin
						next_info = decode_op(byte_in, pw);
						next_abytes = '0;
						next_state = next_info.valid ? ST_ADDR : ST_SKIP;
					end
				end
			end
			ST_ADDR: begin
				if (rise) begin
					next_sh = byte_in;
					next_cnt = byte_done ? 4'h0 : bits_in;
					if (byte_done) begin
						next_addr = addr_full;
						next_abytes = 2'(abytes + 2'h1);
						if (abytes == ADDR_LAST) begin
							next_mem_addr = addr_full[MEM_ADDR_W-1:0];
							if (info.write) begin
								next_state = ST_DIN;
							end else begin
								next_state = ST_DOUT;
								next_rd_req = 1'b1;
								next_tx_left = '0;
							end
						end
					end
				end
			end
			ST_DIN: begin
				if (rise) begin
					next_sh = byte_in;
					next_cnt = byte_done ? 4'h0 : bits_in;
					if (byte_done) begin
						// no busy phase: byte leaves at once, next one may follow
						next_push = 1'b1;
						next_push_word = '{addr: mem_addr, data: byte_in};
						next_mem_addr = MEM_ADDR_W'(mem_addr + 1'b1);
					end
				end
			end
			ST_DOUT: begin
				if (fall) begin
					if (tx_left == '0) begin
						next_lane_out = drive_bits(tx_next, cur_w);
						next_tx = 8'(tx_next << cur_w);
						next_tx_left = BYTE_BITS - {1'b0, cur_w};
						next_mem_addr = MEM_ADDR_W'(mem_addr + 1'b1);
						next_rd_req = 1'b1;
						// drivers turn on at the fall, once the master has let go of the lanes
						next_lane_oe = oe_mask(cur_w);
					end else begin
						next_lane_out = drive_bits(tx, cur_w);
						next_tx = 8'(tx << cur_w);
						next_tx_left = tx_left - {1'b0, cur_w};
					end
				end
			end
			ST_SKIP: next_state = ST_SKIP;
			default: next_state = ST_IDLE;
		endcase
		// deselect or reset pin: back to single lane, lanes released
		if (cs_high || rst_pin) begin
			next_state = ST_IDLE;
			next_info = INFO_IDLE;
			next_lane_oe = '0;
		end
	end
	// a blocked register write needs both the low pin and the disable bit
	assign next_regwr = !(status_write_disable_bit && wp_low);
	// set beats clear: a byte lost in the same cycle as a new frame still shows
	assign next_overrun = (write_overrun && !cs_fall) || (push && !fifo_ready);
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			state <= ST_IDLE;
			info <= INFO_IDLE;
			cs_d <= 1'b1;
			sck_d <= 1'b0;
			sh <= '0;
			cnt <= '0;
			abytes <= '0;
			addr <= '0;
			mem_addr <= '0;
			tx <= '0;
			tx_left <= '0;
			tx_next <= '0;
			rd_pend <= 1'b0;
			rd_req <= 1'b0;
			lane_out <= '0;
			lane_oe <= '0;
			push <= 1'b0;
			push_word <= '0;
			write_overrun <= 1'b0;
			reg_write_allowed <= 1'b1;
			standby <= 1'b1;
		end else begin
			state <= next_state;
			info <= next_info;
			cs_d <= cs_s;
			sck_d <= sck_s;
			sh <= next_sh;
			cnt <= next_cnt;
			abytes <= next_abytes;
			addr <= next_addr;
			mem_addr <= next_mem_addr;
			tx <= next_tx;
			tx_left <= next_tx_left;
			tx_next <= next_tx_next;
			rd_pend <= next_rd_pend;
			rd_req <= next_rd_req;
			lane_out <= next_lane_out;
			lane_oe <= next_lane_oe;
			push <= next_push;
			push_word <= next_push_word;
			write_overrun <= next_overrun;
			reg_write_allowed <= next_regwr;
			standby <= cs_high;
		end
	end
	// ****************************************
	// written bytes toward the user
	// ****************************************
	// the link cannot be stalled; a full buffer drops the byte and flags it
	word_fifo #(.WIDTH($bits(wr_word_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
		.core_clk(core_clk),
		.resetn(resetn),
		.in_valid(push),
		.in_data(push_word),
		.in_ready(fifo_ready),
		.out_valid(wr_valid),
		.out_data(wr_word),
		.out_ready(wr_ready)
	);
	// ****************************************
	// checks
	// ****************************************
	sequence s_opc_done;
		state == ST_OPC && rise && byte_done && !cs_high && !rst_pin;
	endsequence
	sequence s_addr_done;
		state == ST_ADDR && rise && byte_done && abytes == ADDR_LAST && !cs_high && !rst_pin;
	endsequence
	a_standby_quiet: assert property (standby |-> lane_oe == '0)
		else $error("lanes driven while deselected");
	a_oe_read_only: assert property ((lane_oe != '0) |-> state == ST_DOUT && lane_oe == oe_mask(info.data_w))
		else $error("lane drive outside data output");
	a_out_on_fall: assert property ($changed(lane_out) |-> $past(fall))
		else $error("output changed away from falling edge");
	a_first_rise: assert property (state == ST_OPC && cnt == '0 && rise && !cs_high && !rst_pin
		|=> cnt == {1'b0, $past(pw)})
		else $error("first rising edge not counted");
	a_proto_width: assert property (s_opc_done ##1 state == ST_ADDR && pw != W1 |-> info.addr_w == $past(pw))
		else $error("protocol lane width not applied");
	a_addr_to_read: assert property (s_addr_done ##0 !info.write |=> rd_req && state == ST_DOUT ##1 !rd_req)
		else $error("read not started after address");
	a_push_addr: assert property (state == ST_DIN && rise && byte_done && !cs_high && !rst_pin
		|=> push && push_word.addr == $past(mem_addr))
		else $error("written byte at wrong address");
	a_cs_single: assert property (cs_high |=> info == INFO_IDLE && state == ST_IDLE)
		else $error("single lane not restored");
	a_rst_pin: assert property (rst_pin |=> state == ST_IDLE && lane_oe == '0)
		else $error("reset pin ignored");
	a_wp_block: assert property (status_write_disable_bit && wp_low |=> !reg_write_allowed)
		else $error("register write not blocked");
endmodule // spi_front
`default_nettype wire

// ===== rtl/spi_front_pkg.sv
package spi_front_pkg;
	// ****************************************
	// widths and counts
	// ****************************************
	localparam logic [2:0] W1 = 3'h1;
	localparam logic [2:0] W2 = 3'h2;
	localparam logic [2:0] W4 = 3'h4;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [1:0] ADDR_LAST = 2'h2; // index of the third address byte
	localparam int MEM_ADDR_W = 17;
	localparam int FIFO_DEPTH = 8;
	localparam int CFG2_TWO_LANE_BIT = 4;
	localparam int CFG2_FOUR_LANE_BIT = 6;
	localparam int LANE_SI = 0;
	localparam int LANE_WP = 2;
	localparam int LANE_RST = 3;
	localparam logic [3:0] OE_W1 = 4'h2; // single lane answers on lane 1
	localparam logic [3:0] OE_W2 = 4'h3;
	localparam logic [3:0] OE_W4 = 4'hF;
	// ****************************************
	// opcodes handled by this front end
	// ****************************************
	localparam logic [7:0] OPC_READ = 8'h03;
	localparam logic [7:0] OPC_WRITE = 8'h02;
	localparam logic [7:0] OPC_READ_DUAL_DATA = 8'h3B;
	localparam logic [7:0] OPC_READ_DUAL_IO = 8'hBB;
	localparam logic [7:0] OPC_READ_QUAD_DATA = 8'h6B;
	localparam logic [7:0] OPC_READ_QUAD_IO = 8'hEB;
	localparam logic [7:0] OPC_WRITE_QUAD_DATA = 8'h32;
	// ****************************************
	// carriers
	// ****************************************
	typedef struct packed {
		logic valid;
		logic write;
		logic [2:0] addr_w;
		logic [2:0] data_w;
	} op_info_t;
	localparam op_info_t INFO_IDLE = '{valid: 1'b0, write: 1'b0, addr_w: W1, data_w: W1};
	typedef struct packed {
		logic [MEM_ADDR_W-1:0] addr;
		logic [7:0] data;
	} wr_word_t;
endpackage

// ===== rtl/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	input wire logic core_clk, // sampling clock
	input wire logic resetn, // async reset, active low
	input wire logic [WIDTH-1:0] pin, // raw pin levels
	output logic [WIDTH-1:0] synced // levels after two flops
);
	logic [WIDTH-1:0] meta;
	// two flops; only the second one reads the first
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			meta <= INIT;
			synced <= INIT;
		end else begin
			meta <= pin;
			synced <= meta;
		end
	end
endmodule // pin_sync
`default_nettype wire

// ===== rtl/word_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic core_clk, // clock
	input wire logic resetn, // async reset, active low
	input wire logic in_valid, // word offered
	input wire logic [WIDTH-1:0] in_data, // word in
	output logic in_ready, // room for a word
	output logic out_valid, // word held at output
	output logic [WIDTH-1:0] out_data, // registered word out
	input wire logic out_ready // drain side takes word
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
		$error("word_fifo depth must be a power of two, at least 2");
	end
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
	logic [AW:0] count, next_count;
	logic next_out_valid;
	logic [WIDTH-1:0] next_out_data;
	logic push, take;
	// the output word sits in its own register, so storage excludes it
	always_comb begin
		push = in_valid && in_ready;
		take = (count != '0) && (!out_valid || out_ready);
		next_wr_ptr = push ? AW'(wr_ptr + 1'b1) : wr_ptr;
		next_rd_ptr = take ? AW'(rd_ptr + 1'b1) : rd_ptr;
		next_count = AW'(0) + count + (AW+1)'(push) - (AW+1)'(take);
		next_out_valid = take ? 1'b1 : (out_ready ? 1'b0 : out_valid);
		next_out_data = take ? mem[rd_ptr] : out_data;
	end
	assign in_ready = (count != FULL);
	always_ff @(posedge core_clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
			out_valid <= 1'b0;
			out_data <= '0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count <= next_count;
			out_valid <= next_out_valid;
			out_data <= next_out_data;
		end
	end
endmodule // word_fifo
`default_nettype wire

// ===== test/spi_master_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// spi master model
// ****************************************
module spi_master_model (
	input wire logic core_clk, // paces the link
	output logic cs_n, // chip select
	output logic sck, // serial clock
	output logic [3:0] lane_in, // resolved lane levels
	input wire logic [3:0] lane_out, // device drive values
	input wire logic [3:0] lane_oe // device drive enables
);
	logic [3:0] m_val;
	logic [3:0] m_oe;
	logic [7:0] data [16];
	logic [3:0] oe_seen;
	logic cpol;
	logic wp_level;
	logic rst_level;
	logic idle_pat = 1'b0;
	initial begin
		cs_n = 1;
		sck = 0;
		m_val = 0;
		m_oe = 0;
		cpol = 0;
		wp_level = 1;
		rst_level = 1;
		oe_seen = 0;
	end
	// released lanes 0 and 1 wobble so a stale level never passes for data; 2 and 3 pull up
	always @(posedge core_clk) idle_pat <= ~idle_pat;
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			if (lane_oe[i] && m_oe[i]) lane_in[i] = 1'bx; // both ends driving: bus fight
			else if (lane_oe[i]) lane_in[i] = lane_out[i];
			else if (m_oe[i]) lane_in[i] = m_val[i];
			else lane_in[i] = (i == 2) ? wp_level : ((i == 3) ? rst_level : idle_pat);
		end
	end
	// half a link period is five core cycles: 80 ns period, single rate only
	task automatic half();
		repeat (5) @(posedge core_clk);
		#1;
	endtask
	function automatic logic [3:0] mask(input int w);
		return 4'((1 << w) - 1);
	endfunction
	// drive on the low phase, device takes the bit at the rise
	task automatic put_byte(input logic [7:0] b, input int w);
		for (int k = 0; k < 8 / w; k++) begin
			sck = 0;
			m_oe = mask(w);
			m_val = 4'(b >> (8 - w * (k + 1))) & mask(w);
			half();
			sck = 1;
			half();
		end
	endtask
	task automatic get_byte(output logic [7:0] b, input int w);
		b = 8'h00;
		m_oe = 4'h0;
		for (int k = 0; k < 8 / w; k++) begin
			sck = 0;
			half();
			sck = 1;
			oe_seen = lane_oe;
			b = (b << w) | (8'(lane_in >> (w == 1)) & 8'(mask(w)));
			half();
		end
	endtask
	// one opcode per select low period, select raised once the transfer ends
	task automatic frame(input logic [7:0] op, input int wo, input logic [23:0] a, input int wa, input int wd,
			input logic wr, input int n);
		sck = cpol;
		half();
		cs_n = 0;
		half();
		put_byte(op, wo);
		for (int i = 2; i >= 0; i--) put_byte(a[8*i +: 8], wa);
		for (int i = 0; i < n; i++) begin
			if (wr) put_byte(data[i], wd);
			else get_byte(data[i], wd);
		end
		sck = cpol;
		m_oe = 4'h0;
		half();
		cs_n = 1;
		half();
	endtask
endmodule // spi_master_model
`default_nettype wire

// ===== test/tb_spi_front.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// spi front end bench
// ****************************************
module tb_spi_front;
	import spi_front_pkg::*;
	logic core_clk;
	logic resetn;
	logic cs_n;
	logic sck;
	logic [3:0] lane_in;
	logic [3:0] lane_out;
	logic [3:0] lane_oe;
	logic rd_req;
	logic [MEM_ADDR_W-1:0] mem_addr;
	logic [7:0] rd_data;
	logic wr_valid;
	wr_word_t wr_word;
	logic wr_ready;
	logic write_overrun;
	logic status_write_disable_bit;
	logic [7:0] cfg_vol;
	logic [7:0] cfg_nv;
	logic reg_write_allowed;
	logic standby;
	int fails;
	int compares;
	logic [7:0] ops [5] = '{OPC_READ_DUAL_DATA, OPC_READ_DUAL_IO, OPC_READ_QUAD_DATA, OPC_READ_QUAD_IO,
		OPC_WRITE_QUAD_DATA};
	int wa [5] = '{1, 2, 1, 4, 1};
	int wd [5] = '{2, 2, 4, 4, 4};
	initial begin
		core_clk = 0;
		forever #4 core_clk = ~core_clk;
	end
	// memory content is a plain function of the address
	function automatic logic [7:0] mem_byte(input logic [16:0] a);
		return a[7:0] ^ {a[16], 7'h43};
	endfunction
	// registered memory: a byte appears only the cycle after its fetch pulse
	always @(posedge core_clk) begin
		if (rd_req) begin
			rd_data <= mem_byte(mem_addr);
		end
	end
	spi_front dut (.core_clk(core_clk), .resetn(resetn), .cs_n(cs_n), .sck(sck), .lane_in(lane_in),
		.lane_out(lane_out), .lane_oe(lane_oe), .rd_req(rd_req), .mem_addr(mem_addr), .rd_data(rd_data),
		.wr_valid(wr_valid), .wr_word(wr_word), .wr_ready(wr_ready), .write_overrun(write_overrun),
		.status_write_disable_bit(status_write_disable_bit), .second_config_register_vol(cfg_vol),
		.second_config_register_nv(cfg_nv), .reg_write_allowed(reg_write_allowed), .standby(standby));
	spi_master_model m (.core_clk(core_clk), .cs_n(cs_n), .sck(sck), .lane_in(lane_in), .lane_out(lane_out),
		.lane_oe(lane_oe));
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic give_verdict();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic fill(input logic [7:0] seed);
		for (int i = 0; i < 16; i++) m.data[i] = 8'(seed + 8'h1D * i);
	endtask
	// take one written word; the extra cycle lets the next word land
	task automatic pop(input logic [16:0] a, input logic [7:0] d);
		int i;
		i = 0;
		while (wr_valid !== 1'b1 && i < 100) begin
			cyc(1);
			i++;
		end
		chk("wr_word", {7'h00, a, d}, wr_word);
		wr_ready = 1;
		cyc(1);
		wr_ready = 0;
		cyc(1);
	endtask
	task automatic rd_check(input logic [16:0] a, input int n, input logic [3:0] oe);
		for (int i = 0; i < n; i++) chk("read byte", mem_byte(a + 17'(i)), m.data[i]);
		chk("read enables", oe, m.oe_seen);
		chk("idle enables", 4'h0, lane_oe);
	endtask
	// hang guard: the tests need about 10k core cycles, this allows 50k
	initial begin
		#400000;
		fails++;
		give_verdict();
	end
	initial begin
		resetn = 0;
		wr_ready = 0;
		status_write_disable_bit = 0;
		cfg_vol = 8'h00;
		cfg_nv = 8'h00;
		fails = 0;
		compares = 0;
		cyc(2);
		chk("standby", 1, standby);
		chk("reg_write_allowed", 1, reg_write_allowed);
		resetn = 1;
		cyc(4);
		// top of memory, upper address bits ignored, count wraps; modes 0 and 3
		for (int c = 0; c < 2; c++) begin
			m.cpol = 1'(c);
			m.frame(OPC_READ, 1, 24'hFF_FFFF, 1, 1, 0, 3);
			rd_check(17'h1FFFF, 3, OE_W1);
		end
		m.cpol = 0;
		chk("standby", 1, standby);
		fill(8'h21);
		m.frame(OPC_WRITE, 1, 24'h80_0010, 1, 1, 1, 3);
		for (int i = 0; i < 3; i++) pop(17'h00010 + 17'(i), m.data[i]);
		// stalled drain: nine words held, the tenth lost
		fill(8'h47);
		m.frame(OPC_WRITE, 1, 24'h00_0100, 1, 1, 1, 10);
		chk("write_overrun", 1, write_overrun);
		for (int i = 0; i < 9; i++) pop(17'h00100 + 17'(i), m.data[i]);
		chk("wr_valid", 0, wr_valid);
		// each variant picked by its opcode, then plain single lane again
		for (int i = 0; i < 5; i++) begin
			fill(8'(8'h90 + i));
			m.frame(ops[i], 1, 24'h002000 + 24'(i * 16), wa[i], wd[i], ops[i] == OPC_WRITE_QUAD_DATA, 2);
			if (ops[i] == OPC_WRITE_QUAD_DATA) begin
				pop(17'h02040, 8'h94);
				pop(17'h02041, 8'hB1);
			end else begin
				rd_check(17'h02000 + 17'(i * 16), 2, wd[i] == 2 ? OE_W2 : OE_W4);
			end
			m.frame(OPC_READ, 1, 24'h000040, 1, 1, 0, 1);
			rd_check(17'h00040, 1, OE_W1);
		end
		chk("write_overrun", 0, write_overrun);
		// whole-frame protocols from either copy; four lanes win over two
		cfg_nv = 8'h10;
		m.frame(OPC_READ, 2, 24'h000300, 2, 2, 0, 2);
		rd_check(17'h00300, 2, OE_W2);
		cfg_nv = 8'h00;
		cfg_vol = 8'h40;
		fill(8'h3C);
		m.frame(OPC_WRITE, 4, 24'h000400, 4, 4, 1, 2);
		pop(17'h00400, 8'h3C);
		pop(17'h00401, 8'h59);
		cfg_vol = 8'h50;
		m.frame(OPC_READ, 4, 24'h000410, 4, 4, 0, 2);
		rd_check(17'h00410, 2, OE_W4);
		cfg_vol = 8'h00;
		// write protect bites only with the disable bit set
		for (int i = 0; i < 3; i++) begin
			status_write_disable_bit = i < 2;
			m.wp_level = 1'(i);
			cyc(6);
			chk("reg_write_allowed", i != 0, reg_write_allowed);
		end
		m.wp_level = 1;
		status_write_disable_bit = 0;
		// unknown opcode: frame ignored, nothing driven until select rises
		m.frame(8'hA5, 1, 24'h000500, 1, 1, 0, 1);
		chk("enables after unknown opcode", 0, m.oe_seen);
		// reset pin held low: nothing answers; afterwards a fresh frame works
		m.rst_level = 0;
		m.frame(OPC_READ, 1, 24'h000500, 1, 1, 0, 1);
		chk("enables in reset", 0, m.oe_seen);
		m.rst_level = 1;
		cyc(6);
		m.frame(OPC_READ, 1, 24'h000500, 1, 1, 0, 1);
		rd_check(17'h00500, 1, OE_W1);
		give_verdict();
	end
endmodule // tb_spi_front
`default_nettype wire
